// ### design/pmcs_consts.vh
// Constants for the power mode and clock sequencer
`ifndef PMCS_CONSTS_VH
`define PMCS_CONSTS_VH
// Register offsets (byte addresses)
`define PMCS_OFF_CLKSEL    8'h00
`define PMCS_OFF_CPUDIV    8'h04
`define PMCS_OFF_PERCLK    8'h08
`define PMCS_OFF_PERDIV0   8'h0c
`define PMCS_OFF_PERDIV1   8'h10
`define PMCS_OFF_PWRMODE   8'h14
`define PMCS_OFF_PROFILE   8'h18
`define PMCS_OFF_STATUS    8'h1c
`define PMCS_OFF_INT_STAT  8'h20
`define PMCS_OFF_INT_CLR   8'h24
`define PMCS_OFF_INT_EN    8'h28
`define PMCS_OFF_SRCEN     8'h2c
// Clock source codes
`define PMCS_SRC_INTRC     2'h0
`define PMCS_SRC_SYSOSC    2'h1
`define PMCS_SRC_WDOSC     2'h2
`define PMCS_SRC_RTCOSC    2'h3
// Power mode request codes
`define PMCS_MODE_ACTIVE   3'h0
`define PMCS_MODE_SLEEP    3'h1
`define PMCS_MODE_DSLEEP   3'h2
`define PMCS_MODE_PDOWN    3'h3
`define PMCS_MODE_DPDOWN   3'h4
// Power profile codes
`define PMCS_PROF_DEFAULT  2'h0
`define PMCS_PROF_PERF     2'h1
`define PMCS_PROF_EFF      2'h2
`define PMCS_PROF_LOWCUR   2'h3
// Reset values
`define PMCS_RST_CPUDIV    8'h01
`define PMCS_RST_PERCLK    16'hffff
`define PMCS_RST_PERDIV    8'h01
`define PMCS_RST_SRCEN     4'h1
// Interrupt status bit positions
`define PMCS_EV_WAKE       0
`define PMCS_EV_SRCSW      1
`define PMCS_EV_LPENTRY    2
`endif

// ### design/pmcs_clk_div.v
// Clock enable pulse divider with programmable ratio
module pmcs_clk_div #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // Control
  input  wire         run,
  input  wire [W-1:0] ratio,
  // Output tick
  output reg          tick
);
  reg [W-1:0] cnt_reg;

  // Count up to ratio-1; ratio 0 stops the tick, ratio 1 passes every cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
    end else if (!run || ratio == {W{1'b0}}) begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
    end else if (cnt_reg >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      tick    <= 1'b0;
    end
  end
endmodule

// ### design/pmcs_clk_gate.v
// Glitch-free clock enable gate
module pmcs_clk_gate (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst,
  // Request and tick source
  input  wire enable_req,
  input  wire tick_in,
  // Gated enable out
  output reg  gated_tick,
  output reg  enabled
);
  // Registered enable; a tick passes whole or not at all, and none passes once the request drops
  always @(posedge sys_clk) begin
    if (rst) begin
      enabled    <= 1'b1;
      gated_tick <= 1'b0;
    end else begin
      enabled    <= enable_req;
      gated_tick <= tick_in & enable_req;
    end
  end
endmodule

// ### design/pmcs_top.v
// Power mode and clock sequencer top level
// Overview of operation
// - Supports active plus Sleep, Deep-sleep, Power-down and Deep power-down modes.
// - Four clock sources: system, internal RC, watchdog, 32 kHz RTC oscillators.
// - Any reset selects the internal RC oscillator until software chooses another.
// - Power-up and Deep power-down wake run from the 12 MHz internal RC oscillator.
// - CPU rate changes via source, PLL setting or CPU divider.
// - One register gates each peripheral clock individually.
// - Selected peripherals own dividers separate from the CPU divider.
// - Four power profiles: default, performance, efficiency, lowest current.
// - Sleep entry stops the core clock.
// - Execution stays suspended in Sleep until reset, interrupt or the wake pin.
// - Sleep exit just re-enables the core clock.
// - Peripherals run in Sleep; their interrupts wake the core.
//
// The register offsets and the strobed register port are this design's own decisions.
`include "pmcs_consts.vh"
// Register map
// 0x00 clock select: [1:0] source, [2] PLL in use, [13:8] PLL setting
// 0x04 CPU divider ratio: 0 stops the core ticks, 1 passes every cycle
// 0x08 peripheral clock gates: one bit per peripheral, 1 runs the clock
// 0x0c peripheral divider 0 ratio
// 0x10 peripheral divider 1 ratio
// 0x14 power mode request: [2:0] mode code, [8] deep power-down wake flag
// 0x18 power profile code
// 0x1c status: [4:0] state, [8] core clock on, [12:9] sources ready, [13] PLL locked
// 0x20 interrupt status, read only, sticky
// 0x24 interrupt clear, write only, one clears
// 0x28 interrupt enable, same layout as status
// 0x2c oscillator enables, the internal RC bit is forced on
//
// Interrupt events
// Bit 0 wake from any low-power state
// Bit 1 write to the clock select register
// Bit 2 entry into any low-power state
//
// Sequencing notes
// A sleep request is taken only in the run state
// The requested mode comes from the power mode register
// An unknown mode code leaves the core running
// Sleep, deep-sleep and power-down wake on an interrupt or the wake pin
// Deep power-down wakes only on the wake pin
// Deep power-down wake restores the clock selection of reset
// The wake flag tells software that the last wake was from deep power-down
// Software clears that flag by writing one to bit 8 of the mode register
//
// Clock notes
// The core clock is a tick enable, not a derived clock
// The gate closes on the same edge the state leaves run
// So no tick reaches the core once it is halted
// Peripheral ticks continue in sleep but stop in deeper states
// Peripheral clock gate outputs are held closed outside run and sleep; the 0x08 register reads back as written
// Source selection is not checked against readiness
// Software must wait for a source to report ready before selecting it
//
// Register port notes
// Writes take effect on the edge that samples the strobe
// Read data stands for one cycle after the read strobe
// Outside that cycle the read data is zero
// Unmapped reads return zero and unmapped writes are dropped
// The port never stalls the master
//
// Interrupt notes
// A new event wins over a clear in the same cycle
// The interrupt output is a level, high while an enabled bit is set
// Events are counted once per cycle, not queued
module pmcs_top #(
  parameter NPER = 16,
  parameter DW   = 8
) (
  // Clock and reset
  input  wire            sys_clk,
  input  wire            rst,
  // Register port
  input  wire [7:0]      reg_addr,
  input  wire [31:0]     reg_wdata,
  input  wire            reg_wr,
  input  wire            reg_rd,
  output reg  [31:0]     reg_rdata,
  // Core side
  input  wire            core_sleep_req,
  input  wire            wake_irq,
  input  wire            wake_pin,
  output wire            core_clk_en,
  output wire            core_halted,
  // Oscillators and PLL
  input  wire [3:0]      src_ready,
  input  wire            pll_locked,
  output wire [3:0]      src_enable,
  output wire [1:0]      sys_clk_sel,
  output wire            pll_use,
  output wire [5:0]      pll_setting,
  // Peripheral clocks
  output wire [NPER-1:0] per_clk_en,
  output wire [1:0]      per_div_tick,
  // Power state
  output wire [2:0]      pwr_mode,
  output wire [1:0]      pwr_profile,
  output wire            dpd_active,
  output wire            irq
);
  // One-hot sequencer states
  localparam [4:0] ST_RUN   = 5'b00001;
  localparam [4:0] ST_SLEEP = 5'b00010;
  localparam [4:0] ST_DSLP  = 5'b00100;
  localparam [4:0] ST_PDN   = 5'b01000;
  localparam [4:0] ST_DPD   = 5'b10000;

  reg [4:0]      state_reg;
  reg [4:0]      state_next;
  reg [1:0]      clksel_reg;
  reg            pll_use_reg;
  reg [5:0]      pll_set_reg;
  reg [DW-1:0]   cpudiv_reg;
  reg [NPER-1:0] perclk_reg;
  reg [DW-1:0]   perdiv0_reg;
  reg [DW-1:0]   perdiv1_reg;
  reg [2:0]      mode_req_reg;
  reg [1:0]      profile_reg;
  reg [3:0]      srcen_reg;
  reg [2:0]      int_stat_reg;
  reg [2:0]      int_en_reg;
  reg            dpd_wake_reg;

  wire wake       = wake_irq | wake_pin;
  wire cpu_tick;
  wire core_tick;
  wire core_on;
  wire sleeping   = (state_reg != ST_RUN);
  wire [2:0] ev;

  // Register write decode
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Power sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (core_sleep_req) begin
          case (mode_req_reg)
            `PMCS_MODE_SLEEP:  state_next = ST_SLEEP;
            `PMCS_MODE_DSLEEP: state_next = ST_DSLP;
            `PMCS_MODE_PDOWN:  state_next = ST_PDN;
            `PMCS_MODE_DPDOWN: state_next = ST_DPD;
            default:           state_next = ST_RUN;
          endcase
        end
      end
      ST_SLEEP: begin
        if (wake)
          state_next = ST_RUN;
      end
      ST_DSLP, ST_PDN: begin
        if (wake)
          state_next = ST_RUN;
      end
      ST_DPD: begin
        if (wake_pin)
          state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Event sources for the interrupt status
  assign ev[`PMCS_EV_WAKE]    = sleeping && state_next == ST_RUN;
  assign ev[`PMCS_EV_SRCSW]   = reg_wr && hit(reg_addr, `PMCS_OFF_CLKSEL);
  assign ev[`PMCS_EV_LPENTRY] = !sleeping && state_next != ST_RUN;

  // State, configuration and status registers
  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= ST_RUN;
      clksel_reg   <= `PMCS_SRC_INTRC;
      pll_use_reg  <= 1'b0;
      pll_set_reg  <= 6'h00;
      cpudiv_reg   <= `PMCS_RST_CPUDIV;
      perclk_reg   <= `PMCS_RST_PERCLK;
      perdiv0_reg  <= `PMCS_RST_PERDIV;
      perdiv1_reg  <= `PMCS_RST_PERDIV;
      mode_req_reg <= `PMCS_MODE_ACTIVE;
      profile_reg  <= `PMCS_PROF_DEFAULT;
      srcen_reg    <= `PMCS_RST_SRCEN;
      int_stat_reg <= 3'h0;
      int_en_reg   <= 3'h0;
      dpd_wake_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Deep power-down wake falls back to the internal RC oscillator
      if (state_reg == ST_DPD && state_next == ST_RUN) begin
        clksel_reg   <= `PMCS_SRC_INTRC;
        pll_use_reg  <= 1'b0;
        srcen_reg    <= `PMCS_RST_SRCEN;
        dpd_wake_reg <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `PMCS_OFF_CLKSEL)) begin
        clksel_reg  <= reg_wdata[1:0];
        pll_use_reg <= reg_wdata[2];
        pll_set_reg <= reg_wdata[13:8];
      end else if (reg_wr && hit(reg_addr, `PMCS_OFF_SRCEN)) begin
        srcen_reg <= reg_wdata[3:0];
      end
      if (reg_wr && hit(reg_addr, `PMCS_OFF_CPUDIV))
        cpudiv_reg <= reg_wdata[DW-1:0];
      if (reg_wr && hit(reg_addr, `PMCS_OFF_PERCLK))
        perclk_reg <= reg_wdata[NPER-1:0];
      if (reg_wr && hit(reg_addr, `PMCS_OFF_PERDIV0))
        perdiv0_reg <= reg_wdata[DW-1:0];
      if (reg_wr && hit(reg_addr, `PMCS_OFF_PERDIV1))
        perdiv1_reg <= reg_wdata[DW-1:0];
      if (reg_wr && hit(reg_addr, `PMCS_OFF_PWRMODE)) begin
        mode_req_reg <= reg_wdata[2:0];
        if (reg_wdata[8])
          dpd_wake_reg <= 1'b0;
      end
      if (reg_wr && hit(reg_addr, `PMCS_OFF_PROFILE))
        profile_reg <= reg_wdata[1:0];
      if (reg_wr && hit(reg_addr, `PMCS_OFF_INT_EN))
        int_en_reg <= reg_wdata[2:0];
      // Set wins over a clear in the same cycle
      if (reg_wr && hit(reg_addr, `PMCS_OFF_INT_CLR))
        int_stat_reg <= (int_stat_reg & ~reg_wdata[2:0]) | ev;
      else
        int_stat_reg <= int_stat_reg | ev;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `PMCS_OFF_CLKSEL:   reg_rdata <= {18'h0, pll_set_reg, 5'h0, pll_use_reg, clksel_reg};
        `PMCS_OFF_CPUDIV:   reg_rdata <= {{(32-DW){1'b0}}, cpudiv_reg};
        `PMCS_OFF_PERCLK:   reg_rdata <= {{(32-NPER){1'b0}}, perclk_reg};
        `PMCS_OFF_PERDIV0:  reg_rdata <= {{(32-DW){1'b0}}, perdiv0_reg};
        `PMCS_OFF_PERDIV1:  reg_rdata <= {{(32-DW){1'b0}}, perdiv1_reg};
        `PMCS_OFF_PWRMODE:  reg_rdata <= {23'h0, dpd_wake_reg, 5'h0, mode_req_reg};
        `PMCS_OFF_PROFILE:  reg_rdata <= {30'h0, profile_reg};
        `PMCS_OFF_STATUS:   reg_rdata <= {18'h0, pll_locked, src_ready, core_on, 3'h0, state_reg};
        `PMCS_OFF_INT_STAT: reg_rdata <= {29'h0, int_stat_reg};
        `PMCS_OFF_INT_EN:   reg_rdata <= {29'h0, int_en_reg};
        `PMCS_OFF_SRCEN:    reg_rdata <= {28'h0, srcen_reg};
        default:            reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // CPU clock divider tick
  pmcs_clk_div #(.W(DW)) u_cpu_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (1'b1),
    .ratio   (cpudiv_reg),
    .tick    (cpu_tick)
  );

  // Core clock gate, closed in every low-power state
  pmcs_clk_gate u_core_gate (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .enable_req (state_next == ST_RUN),
    .tick_in    (cpu_tick),
    .gated_tick (core_tick),
    .enabled    (core_on)
  );

  // Peripheral dividers keep running in Sleep only
  pmcs_clk_div #(.W(DW)) u_per_div0 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (state_reg == ST_RUN || state_reg == ST_SLEEP),
    .ratio   (perdiv0_reg),
    .tick    (per_div_tick[0])
  );

  pmcs_clk_div #(.W(DW)) u_per_div1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (state_reg == ST_RUN || state_reg == ST_SLEEP),
    .ratio   (perdiv1_reg),
    .tick    (per_div_tick[1])
  );

  // Output drive
  assign core_clk_en = core_tick;
  assign core_halted = !core_on;
  assign per_clk_en  = (state_reg == ST_RUN || state_reg == ST_SLEEP) ? perclk_reg : {NPER{1'b0}};
  assign src_enable  = srcen_reg | 4'h1;
  assign sys_clk_sel = clksel_reg;
  assign pll_use     = pll_use_reg;
  assign pll_setting = pll_set_reg;
  assign pwr_mode    = (state_reg == ST_SLEEP) ? `PMCS_MODE_SLEEP :
                       (state_reg == ST_DSLP)  ? `PMCS_MODE_DSLEEP :
                       (state_reg == ST_PDN)   ? `PMCS_MODE_PDOWN :
                       (state_reg == ST_DPD)   ? `PMCS_MODE_DPDOWN : `PMCS_MODE_ACTIVE;
  assign pwr_profile = profile_reg;
  assign dpd_active  = (state_reg == ST_DPD);
  assign irq         = |(int_stat_reg & int_en_reg);
endmodule

// ### verif/pmcs_asserts.sv
// Concurrent checks on the sequencer top-level ports
`include "pmcs_consts.vh"
module pmcs_asserts #(
  parameter NPER = 16
) (
  // Clock and reset
  input logic            sys_clk,
  input logic            rst,
  // Watched ports
  input logic            wake_irq,
  input logic            wake_pin,
  input logic            core_clk_en,
  input logic            core_halted,
  input logic [1:0]      sys_clk_sel,
  input logic [NPER-1:0] per_clk_en,
  input logic [2:0]      pwr_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Core clock gating and restore
  halt_no_tick_a: assert property (core_halted |-> !core_clk_en)
    else $error("core tick while halted");
  sleep_gate_a: assert property (pwr_mode == 3'h1 && $past(pwr_mode) == 3'h0 |-> ##[0:2] core_halted)
    else $error("core clock not stopped");
  sleep_hold_a: assert property (pwr_mode == 3'h1 && !wake_irq && !wake_pin |=> pwr_mode == 3'h1)
    else $error("sleep left without wake");
  sleep_wake_a: assert property (pwr_mode == 3'h1 && wake_irq |=> pwr_mode == 3'h0 ##[1:6] core_clk_en)
    else $error("no resume after wake");
  sleep_per_a: assert property (pwr_mode == 3'h1 && $past(pwr_mode) == 3'h0 |-> per_clk_en == $past(per_clk_en))
    else $error("peripheral clocks changed on sleep");
  // Deepest mode hold and exit, and the state after reset
  dpd_hold_a: assert property (pwr_mode == 3'h4 && !wake_pin |=> pwr_mode == 3'h4)
    else $error("deep power-down left without pin");
  dpd_wake_a: assert property (pwr_mode == 3'h4 && wake_pin |=> pwr_mode == 3'h0 ##[0:1] sys_clk_sel == 2'h0)
    else $error("pin wake not on rc oscillator");
  reset_src_a: assert property ($past(rst) |-> sys_clk_sel == `PMCS_SRC_INTRC && pwr_mode == 3'h0)
    else $error("reset state wrong");
endmodule
bind pmcs_top pmcs_asserts #(.NPER(NPER)) chk_u (.sys_clk, .rst, .wake_irq, .wake_pin, .core_clk_en,
  .core_halted, .sys_clk_sel, .per_clk_en, .pwr_mode);

// ### verif/pmcs_core_model.sv
// Model of the core, its interrupt sources and the oscillators
module pmcs_core_model (
  // Clock and reset
  input  logic        sys_clk,
  input  logic        rst,
  // Bench controls
  input  logic        sleep_go,
  input  logic [7:0]  wake_after,
  // From the sequencer
  input  logic [2:0]  pwr_mode,
  input  logic        core_clk_en,
  input  logic [3:0]  src_enable,
  input  logic        pll_use,
  // To the sequencer and bench
  output logic        core_sleep_req,
  output logic        wake_irq,
  output logic [3:0]  src_ready,
  output logic        pll_locked,
  output logic [15:0] tick_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_cnt;
  // Oscillators settle a cycle after enable; a peripheral interrupt fires after a set delay
  always @(posedge sys_clk) begin
    if (rst) begin
      core_sleep_req <= 1'b0;
      wake_irq <= 1'b0;
      src_ready <= 4'h0;
      pll_locked <= 1'b0;
      tick_cnt <= 16'h0;
      wait_cnt <= 8'h0;
    end else begin
      src_ready <= src_enable;
      pll_locked <= pll_use;
      tick_cnt <= tick_cnt + {15'h0, core_clk_en};
      core_sleep_req <= sleep_go;
      if (pwr_mode != 3'h0 && wake_after != 8'h0) begin
        wait_cnt <= wait_cnt + 8'h1;
        wake_irq <= (wait_cnt + 8'h1 >= wake_after);
      end else begin
        wait_cnt <= 8'h0;
        wake_irq <= 1'b0;
      end
    end
  end
endmodule

// ### verif/pmcs_top_bench.sv
// Self-checking bench for the power mode and clock sequencer
`include "pmcs_consts.vh"
module pmcs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sleep_go = 1'b0, wake_pin = 1'b0;
  logic [7:0] reg_addr = 8'h0, wake_after = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic core_sleep_req, wake_irq, core_clk_en, core_halted, pll_locked, pll_use, dpd_active, irq;
  logic [3:0] src_ready, src_enable;
  logic [1:0] sys_clk_sel, per_div_tick, pwr_profile;
  logic [5:0] pll_setting;
  logic [15:0] per_clk_en, tick_cnt, t0;
  logic [2:0] pwr_mode;
  int miscompares = 0, checks_done = 0, i;
  always #2 sys_clk = ~sys_clk;
  // Design, core model
  pmcs_top #(.NPER(16), .DW(8)) dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_sleep_req, .wake_irq, .wake_pin, .core_clk_en, .core_halted, .src_ready, .pll_locked, .src_enable,
    .sys_clk_sel, .pll_use, .pll_setting, .per_clk_en, .per_div_tick, .pwr_mode, .pwr_profile, .dpd_active, .irq);
  pmcs_core_model core_u (.sys_clk, .rst, .sleep_go, .wake_after, .pwr_mode, .core_clk_en, .src_enable,
    .pll_use, .core_sleep_req, .wake_irq, .src_ready, .pll_locked, .tick_cnt);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1 check(nm, reg_rdata, exp);
    cyc(1);
  endtask
  task automatic enter(input logic [2:0] m);
    wr(`PMCS_OFF_PWRMODE, {29'h0, m});
    sleep_go <= 1'b1;
    cyc(1);
    sleep_go <= 1'b0;
    cyc(3);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    cyc(5000);
    miscompares++;
    end_of_test;
  end
  // Test sequence
  initial begin
    cyc(5);
    rst <= 1'b0;
    rd(`PMCS_OFF_CLKSEL, 32'h0, "clksel");
    rd(`PMCS_OFF_CPUDIV, 32'h1, "cpudiv");
    rd(`PMCS_OFF_PERCLK, 32'hffff, "perclk");
    rd(`PMCS_OFF_PERDIV0, 32'h1, "perdiv");
    rd(`PMCS_OFF_SRCEN, 32'h1, "srcen");
    rd(8'h3c, 32'h0, "unmapped");
    $display("reset test done");
    // Every source selected after it is enabled and settled
    for (i = 0; i < 4; i++) begin
      wr(`PMCS_OFF_SRCEN, 32'h1 | (32'h1 << i));
      wr(`PMCS_OFF_CLKSEL, {18'h0, 6'h2a, 5'h0, 1'b1, i[1:0]});
      #1 check("sel", {pll_use, pll_setting, sys_clk_sel}, {1'b1, 6'h2a, i[1:0]});
    end
    rd(`PMCS_OFF_INT_STAT, 32'h2, "stat");
    check("irq off", irq, 1'b0);
    wr(`PMCS_OFF_INT_EN, 32'h7);
    #1 check("irq on", irq, 1'b1);
    wr(`PMCS_OFF_INT_CLR, 32'h2);
    #1 check("irq clr", irq, 1'b0);
    $display("source test done");
    // Profiles, ending on the default one
    for (i = 3; i >= 0; i--) begin
      wr(`PMCS_OFF_PROFILE, i);
      #1 check("profile", pwr_profile, i[1:0]);
    end
    wr(`PMCS_OFF_CPUDIV, 32'h4);
    cyc(8);
    t0 = tick_cnt;
    cyc(40);
    check("cpu ticks", tick_cnt - t0, 16'd10);
    wr(`PMCS_OFF_CPUDIV, 32'h1);
    wr(`PMCS_OFF_PERCLK, 32'h00a5);
    wr(`PMCS_OFF_PERDIV0, 32'h0);
    cyc(3);
    #1 check("perclk", per_clk_en, 16'h00a5);
    repeat (6) begin
      cyc(1);
      #1 check("pdiv", per_div_tick, 2'b10);
    end
    $display("divider test done");
    // Sleep, deep-sleep, power-down with prompt and slow wakes
    for (i = 1; i < 4; i++) begin
      wake_after <= 8'(12 * i);
      enter(i[2:0]);
      check("mode", pwr_mode, i[2:0]);
      check("halted", core_halted, 1'b1);
      t0 = tick_cnt;
      cyc(4);
      check("frozen", tick_cnt, t0);
      check("per", per_clk_en, i == 1 ? 16'h00a5 : 16'h0);
      cyc(40);
      check("woke", {pwr_mode, core_halted}, 4'h0);
      rd(`PMCS_OFF_INT_STAT, 32'h5, "wake stat");
      wr(`PMCS_OFF_INT_CLR, 32'h7);
    end
    // Deep power-down ignores the interrupt, leaves on the pin
    wr(`PMCS_OFF_SRCEN, 32'h3);
    wr(`PMCS_OFF_CLKSEL, 32'h1);
    wake_after <= 8'd2;
    enter(`PMCS_MODE_DPDOWN);
    cyc(10);
    #1 check("dpd", {dpd_active, pwr_mode}, {1'b1, `PMCS_MODE_DPDOWN});
    wake_pin <= 1'b1;
    cyc(2);
    wake_pin <= 1'b0;
    cyc(2);
    #1 check("dpd wake", {pwr_mode, sys_clk_sel, src_enable}, {3'h0, `PMCS_SRC_INTRC, `PMCS_RST_SRCEN});
    $display("mode test done");
    // Reset in mid-run returns to the rc oscillator
    wr(`PMCS_OFF_CLKSEL, 32'h2);
    #1 check("sel2", sys_clk_sel, 2'h2);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    #1 check("rst sel", sys_clk_sel, `PMCS_SRC_INTRC);
    $display("reset rerun done");
    end_of_test;
  end
endmodule
